// ---- hw/hsbp_map.vh ----
// register addresses, field positions and reset values of the host slave buffer port
`ifndef HSBP_MAP_VH
`define HSBP_MAP_VH
`define HSBP_ADDR_BUFFER 8'h80
`define HSBP_ADDR_CONTROL 8'hD8
`define HSBP_ADDR_STATUS 8'hDA
`define HSBP_ADDR_PORT2 8'hA0
`define HSBP_CTL_IRQ_EN 3
`define HSBP_CTL_DMA 2
`define HSBP_CTL_MODE 1
`define HSBP_ST_LAST_SEL 3
`define HSBP_ST_USER_FLAG 2
`define HSBP_ST_IN_FULL 1
`define HSBP_ST_OUT_FULL 0
`define HSBP_CTL_RESET 8'h00
`define HSBP_ST_RESET 8'h00
`define HSBP_ST_CPU_MASK 8'hF4
`define HSBP_P2_DRQ_BIT 6
`endif

// ---- hw/hsbp_fifo.v ----
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module hsbp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clock,
  input wire rst,
  input wire clk_en,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready & clk_en;
  assign pop = out_valid & out_ready & clk_en;
  always @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ---- hw/hsbp_port.v ----
// host slave buffer port: host data/control pins, buffers, status and control registers
`timescale 1ns/1ns
`include "hsbp_map.vh"
// Overview of operation
// - mode enable turns port 0 into host data bus, port 2 into host controls
// - select low/high: read picks output buffer/status, write picks data/command
// - port 2 bits: select, chip select, read, write, out-full, in-empty, request, grant
// - host write copies data bus into input buffer and sets input-full
// - writes ignored while input-full; cpu read of input buffer clears it
// - cpu write to output buffer sets output-full; blocked until host reads
// - host read of output buffer drives contents and clears output-full
// - host status read drives the status register
// - accepted host write stores its register select in status bit 3
// - status bits 7..4 and 2 cpu writable; bit 1 input-full, bit 0 output-full
// - full flags change only through buffer accesses or mode enable clear, never by status writes
// - all status bits clear while mode enable is zero
// - input-full interrupt, when enabled, raised by filling host write
// - drive output-full pin and active-high input-empty pin
// - buffers at address 80h by context, status at 0DAh
// - transfer-mode bit enables dma, drops request; software raises it via port 2 bit 6
// - dma ends on clearing transfer mode, reset or leaving slave mode
// - firmware writes new output word only after output-full is zero
// - irq enable and transfer mode writable only in slave mode; cleared otherwise
// - mode enable cleared on reset, cpu readable and writable always
module hsbp_port #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // clock, reset, enable
  input wire clock,
  input wire rst,
  input wire clk_en,
  // cpu special-function register access
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_q,
  // port 0 host data pins
  input wire [7:0] p0_in,
  output reg [7:0] p0_out_q,
  output reg [7:0] p0_oe_q,
  // port 2 host control pins
  input wire [7:0] p2_in,
  output reg [7:0] p2_out_q,
  output reg [7:0] p2_oe_q,
  // status to the rest of the core
  output reg slave_mode_q,
  output reg input_full_irq_q,
  output reg transfer_granted_q,
  // host words collected in the receive fifo, drained by firmware logic
  output reg rx_valid_q,
  input wire rx_ready,
  output reg [7:0] rx_data_q
);
  reg [7:0] ctl_q;
  reg [7:0] st_q;
  reg [7:0] in_buf_q;
  reg [7:0] out_buf_q;
  reg drq_latch_q;
  reg rd_act_q;
  reg wr_act_q;
  wire mode;
  wire reg_sel;
  wire cs_n;
  wire rd_n;
  wire wr_n;
  wire grant_n;
  wire host_rd;
  wire host_wr;
  wire rd_start;
  wire rd_end;
  wire wr_start;
  wire accept_wr;
  wire cpu_in_rd;
  wire cpu_out_wr;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire fifo_pop;
  reg [7:0] rdata_d;

  assign mode = ctl_q[`HSBP_CTL_MODE];
  // port 2 pin assignment
  assign reg_sel = p2_in[0];
  assign cs_n = p2_in[1];
  assign rd_n = p2_in[2];
  assign wr_n = p2_in[3];
  assign grant_n = p2_in[7];
  // decode of strobes per chip select
  assign host_rd = mode & ~cs_n & ~rd_n & wr_n;
  assign host_wr = mode & ~cs_n & rd_n & ~wr_n;
  // act on strobe edges so a long strobe counts once
  assign rd_start = host_rd & ~rd_act_q;
  assign rd_end = ~host_rd & rd_act_q;
  assign wr_start = host_wr & ~wr_act_q;
  // lockout also holds while the fifo is full, so buffer and fifo take the same host words
  assign accept_wr = wr_start & ~st_q[`HSBP_ST_IN_FULL] & fifo_in_ready;
  assign cpu_in_rd = sfr_rd & (sfr_addr == `HSBP_ADDR_BUFFER) & mode;
  assign cpu_out_wr = sfr_wr & (sfr_addr == `HSBP_ADDR_BUFFER) & mode
    & ~st_q[`HSBP_ST_OUT_FULL];
  // the output slice reloads whenever it is empty or being taken, so no word is doubled
  assign fifo_pop = (~rx_valid_q | rx_ready) & fifo_out_valid;

  // each host word is also queued for streaming consumers
  hsbp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rx_fifo (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(accept_wr),
    .in_ready(fifo_in_ready),
    .in_data(p0_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  always @* begin
    rdata_d = 8'h00;
    case (sfr_addr)
      `HSBP_ADDR_BUFFER: rdata_d = in_buf_q;
      `HSBP_ADDR_CONTROL: rdata_d = ctl_q;
      `HSBP_ADDR_STATUS: rdata_d = st_q;
      `HSBP_ADDR_PORT2: rdata_d = {1'b0, drq_latch_q, 6'h00};
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_q <= `HSBP_CTL_RESET;
      st_q <= `HSBP_ST_RESET;
      in_buf_q <= 8'h00;
      out_buf_q <= 8'h00;
      drq_latch_q <= 1'b0;
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      sfr_rdata_q <= 8'h00;
      p0_out_q <= 8'h00;
      p0_oe_q <= 8'h00;
      p2_out_q <= 8'h00;
      p2_oe_q <= 8'h00;
      slave_mode_q <= 1'b0;
      input_full_irq_q <= 1'b0;
      transfer_granted_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_data_q <= 8'h00;
    end else if (clk_en) begin
      rd_act_q <= host_rd;
      wr_act_q <= host_wr;
      if (sfr_rd) begin
        sfr_rdata_q <= rdata_d;
      end
      // control register
      if (sfr_wr && sfr_addr == `HSBP_ADDR_CONTROL) begin
        ctl_q[`HSBP_CTL_MODE] <= sfr_wdata[`HSBP_CTL_MODE];
        if (sfr_wdata[`HSBP_CTL_MODE]) begin
          ctl_q[`HSBP_CTL_IRQ_EN] <= mode & sfr_wdata[`HSBP_CTL_IRQ_EN];
          ctl_q[`HSBP_CTL_DMA] <= mode & sfr_wdata[`HSBP_CTL_DMA];
        end else begin
          ctl_q[`HSBP_CTL_IRQ_EN] <= 1'b0;
          ctl_q[`HSBP_CTL_DMA] <= 1'b0;
        end
        if (sfr_wdata[`HSBP_CTL_DMA] & ~ctl_q[`HSBP_CTL_DMA]) begin
          drq_latch_q <= 1'b0;
        end
      end
      // port 2 latch bit 6 raises the transfer request
      if (sfr_wr && sfr_addr == `HSBP_ADDR_PORT2 && ctl_q[`HSBP_CTL_DMA]) begin
        drq_latch_q <= sfr_wdata[`HSBP_P2_DRQ_BIT];
      end
      if (!ctl_q[`HSBP_CTL_DMA]) begin
        drq_latch_q <= 1'b0;
      end
      // status register
      if (!mode) begin
        st_q <= `HSBP_ST_RESET;
      end else begin
        if (sfr_wr && sfr_addr == `HSBP_ADDR_STATUS) begin
          st_q <= (st_q & ~`HSBP_ST_CPU_MASK) | (sfr_wdata & `HSBP_ST_CPU_MASK);
        end
        if (cpu_in_rd) begin
          st_q[`HSBP_ST_IN_FULL] <= 1'b0;
        end
        if (accept_wr) begin
          in_buf_q <= p0_in;
          st_q[`HSBP_ST_IN_FULL] <= 1'b1;
          st_q[`HSBP_ST_LAST_SEL] <= reg_sel;
        end
        if (cpu_out_wr) begin
          out_buf_q <= sfr_wdata;
          st_q[`HSBP_ST_OUT_FULL] <= 1'b1;
        end
        // clear at end of the host read so the data stays stable under the strobe
        if (rd_end && !reg_sel && !cpu_out_wr) begin
          st_q[`HSBP_ST_OUT_FULL] <= 1'b0;
        end
      end
      // host data bus
      if (host_rd) begin
        p0_out_q <= reg_sel ? st_q : out_buf_q;
        p0_oe_q <= 8'hFF;
      end else begin
        p0_out_q <= 8'h00;
        p0_oe_q <= 8'h00;
      end
      // host control outputs on port 2 bits 4..6
      p2_out_q <= {1'b0, drq_latch_q & ctl_q[`HSBP_CTL_DMA],
        ~st_q[`HSBP_ST_IN_FULL], st_q[`HSBP_ST_OUT_FULL], 4'h0};
      p2_oe_q <= mode ? 8'h70 : 8'h00;
      slave_mode_q <= mode;
      input_full_irq_q <= ctl_q[`HSBP_CTL_IRQ_EN] & st_q[`HSBP_ST_IN_FULL];
      transfer_granted_q <= ctl_q[`HSBP_CTL_DMA] & ~grant_n;
      // stream output register slice
      if (~rx_valid_q | rx_ready) begin
        rx_valid_q <= fifo_out_valid;
        rx_data_q <= fifo_out_data;
      end
    end
  end
endmodule

// ---- tb/hsbp_monitor.sv ----
// assertion checker bound to the host slave buffer port
`timescale 1ns/1ns
module hsbp_monitor (
  // clock and reset
  input wire clock,
  input wire rst,
  // cpu side
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  // host pins
  input wire [7:0] p0_oe_q,
  input wire [7:0] p2_in,
  input wire [7:0] p2_out_q,
  input wire [7:0] p2_oe_q,
  // core side
  input wire slave_mode_q,
  input wire input_full_irq_q,
  input wire transfer_granted_q,
  input wire rx_valid_q,
  input wire rx_ready,
  input wire [7:0] rx_data_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_oe_in_mode: assert property (slave_mode_q [*2] |-> p2_oe_q == 8'h70)
    else $error("port 2 directions wrong in slave mode");
  a_quiet_when_off: assert property (!slave_mode_q [*2] |-> p2_oe_q == 8'h00 && p0_oe_q == 8'h00
    && !p2_out_q[4] && !input_full_irq_q && !transfer_granted_q)
    else $error("outputs active with slave mode off");
  a_irq_pin_agree: assert property (input_full_irq_q |-> !p2_out_q[5])
    else $error("irq raised while input-empty pin high");
  a_bus_released: assert property (p2_in[1] [*3] |-> p0_oe_q == 8'h00)
    else $error("data bus driven while not selected");
  a_read_drives: assert property ((slave_mode_q && p2_in[2:1] == 2'b00) [*4] |-> p0_oe_q == 8'hFF)
    else $error("data bus not driven during host read");
  a_out_full_set: assert property (sfr_wr && sfr_addr == 8'h80 && slave_mode_q && !p2_out_q[4]
    |-> ##2 p2_out_q[4])
    else $error("output-full pin not raised by buffer write");
  a_grant_cause: assert property (transfer_granted_q |-> !$past(p2_in[7]) || !$past(p2_in[7], 2))
    else $error("grant reported without grant input low");
  a_rx_hold: assert property (rx_valid_q && !rx_ready |=> rx_valid_q && $stable(rx_data_q))
    else $error("stalled host word changed or dropped");
endmodule
bind hsbp_port hsbp_monitor mon (.*);

// ---- tb/hsbp_host_model.sv ----
// host processor model driving the port 2 controls and the port 0 data bus
`timescale 1ns/1ns
module hsbp_host_model (
  // clock
  input wire clock,
  // device pin drives
  input wire [7:0] p0_out_q,
  input wire [7:0] p0_oe_q,
  input wire [7:0] p2_out_q,
  input wire [7:0] p2_oe_q,
  // resolved pin levels
  output wire [7:0] p0_in,
  output wire [7:0] p2_in
);
  logic [7:0] d = 8'h00, last = 8'h00;
  logic en = 0, sel = 0, cs_n = 1, rd_n = 1, wr_n = 1, grant_n = 1;
  // released data bus shows the inverse of its last level, never a stale copy
  assign p0_in = (p0_oe_q & p0_out_q) | (~p0_oe_q & (en ? d : ~last));
  // undriven port 2 pins idle high on their weak pull-ups
  assign p2_in = (p2_oe_q & p2_out_q) | (~p2_oe_q & {grant_n, 3'b111, wr_n, rd_n, cs_n, sel});
  always @(posedge clock) if (en || p0_oe_q != 8'h00) last <= p0_in;
  task automatic wr(input logic s, input logic [7:0] v);
    d = v;
    en = 1;
    sel = s;
    cs_n = 0;
    @(negedge clock);
    wr_n = 0;
    repeat (3) @(negedge clock);
    wr_n = 1;
    @(negedge clock);
    en = 0;
    cs_n = 1;
    @(negedge clock);
  endtask
  task automatic rd(input logic s, output logic [7:0] v);
    sel = s;
    cs_n = 0;
    @(negedge clock);
    rd_n = 0;
    repeat (4) @(negedge clock);
    v = p0_in;
    rd_n = 1;
    repeat (2) @(negedge clock);
    cs_n = 1;
    @(negedge clock);
  endtask
endmodule

// ---- tb/hsbp_tb.sv ----
// self-checking bench for the host slave buffer port
`timescale 1ns/1ns
module tb;
  logic clock = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, rx_ready = 0, s, lsel = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v, r;
  logic [7:0] q[$];
  wire [7:0] p0_in, p2_in, p0_out_q, p0_oe_q, p2_out_q, p2_oe_q, rx_data_q, sfr_rdata_q;
  wire slave_mode_q, input_full_irq_q, transfer_granted_q, rx_valid_q;
  int err_total = 0, n_tests = 0, i;
  hsbp_port uut (.clk_en(1'b1), .*);
  hsbp_host_model host (.*);
  always #50 clock = ~clock;
  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw(input logic [7:0] a, d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(negedge clock);
    sfr_wr = 0;
  endtask
  task automatic rc(input logic [7:0] a, e);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1;
    @(negedge clock);
    sfr_rd = 0;
    chk(sfr_rdata_q, e);
  endtask
  function automatic logic [7:0] st(input logic sel, inf, outf);
    st = 8'hF4 | {4'h0, sel, 1'b0, inf, outf};
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    v = $urandom(32'hF027);
    repeat (12) @(negedge clock);
    rst = 0;
    rc(8'hD8, 8'h00);
    sw(8'hD8, 8'h0C);
    rc(8'hD8, 8'h00);
    sw(8'hDA, 8'hF4);
    rc(8'hDA, 8'h00);
    sw(8'hD8, 8'h02);
    sw(8'hD8, 8'h0E);
    rc(8'hD8, 8'h0E);
    chk(p2_oe_q, 8'h70);
    sw(8'hDA, 8'hFF);
    rc(8'hDA, 8'hF4);
    host.rd(1, r);
    chk(r, 8'hF4);
    // stream stalled: sixteen fifo words plus the output slice fill it, the next is refused
    for (i = 0; i < 18; i++) begin
      {s, v} = 9'($urandom);
      host.wr(s, v);
      host.wr(~s, ~v);
      if (i < 17) begin
        lsel = s;
        q.push_back(v);
        chk({7'h00, input_full_irq_q}, 8'h01);
        chk(p2_out_q & 8'h20, 8'h00);
        rc(8'hDA, st(s, 1, 0));
        rc(8'h80, v);
      end
      rc(8'hDA, st(lsel, 0, 0));
    end
    rx_ready = 1;
    for (i = 0; i < 100 && q.size() > 0; i++) begin
      if (rx_valid_q === 1'b1) chk(rx_data_q, q.pop_front());
      @(negedge clock);
    end
    if (q.size() != 0) err_total++;
    v = $urandom;
    sw(8'h80, v);
    sw(8'h80, ~v);
    rc(8'hDA, st(lsel, 0, 1));
    chk(p2_out_q & 8'h10, 8'h10);
    host.rd(0, r);
    chk(r, v);
    host.rd(1, r);
    chk(r, st(lsel, 0, 0));
    sw(8'h80, ~v);
    host.rd(0, r);
    chk(r, ~v);
    sw(8'hA0, 8'h40);
    rc(8'hA0, 8'h40);
    repeat (2) @(negedge clock);
    chk(p2_out_q & 8'h40, 8'h40);
    host.grant_n = 0;
    repeat (3) @(negedge clock);
    chk({7'h00, transfer_granted_q}, 8'h01);
    sw(8'hD8, 8'h0A);
    repeat (2) @(negedge clock);
    chk({7'h00, transfer_granted_q}, 8'h00);
    sw(8'hD8, 8'h0E);
    repeat (2) @(negedge clock);
    chk(p2_out_q & 8'h40, 8'h00);
    sw(8'hD8, 8'h00);
    rc(8'hDA, 8'h00);
    rc(8'hD8, 8'h00);
    host.rd(1, r);
    print_verdict;
  end
endmodule
